// ===== ltqc_top.sv
// link transmit queue command handler with axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "ltqc_defines.svh"
module ltqc_top #(
   parameter int          NUM_LINKS = 8,
   parameter int          LINK_W    = 3,
   parameter logic [31:0] LT_BASE   = 32'h0000_1000, // link table area base
   parameter logic [31:0] LT_STRIDE = 32'h0000_0040  // bytes per link table
) (
   input  wire logic                 clk,             // 250 mhz clock
   input  wire logic                 rstn,            // async reset, active low
   input  wire logic [7:0]           s_axi_awaddr,    // write address
   input  wire logic                 s_axi_awvalid,   // write address valid
   output var  logic                 s_axi_awready,   // write address ready
   input  wire ltqc_pkg::ltqc_word_t s_axi_wdata,     // write data
   input  wire logic [3:0]           s_axi_wstrb,     // write strobes
   input  wire logic                 s_axi_wvalid,    // write data valid
   output var  logic                 s_axi_wready,    // write data ready
   output var  logic [1:0]           s_axi_bresp,     // write response
   output var  logic                 s_axi_bvalid,    // write response valid
   input  wire logic                 s_axi_bready,    // write response ready
   input  wire logic [7:0]           s_axi_araddr,    // read address
   input  wire logic                 s_axi_arvalid,   // read address valid
   output var  logic                 s_axi_arready,   // read address ready
   output var  ltqc_pkg::ltqc_word_t s_axi_rdata,     // read data
   output var  logic [1:0]           s_axi_rresp,     // read response
   output var  logic                 s_axi_rvalid,    // read valid
   input  wire logic                 s_axi_rready,    // read ready
   input  wire logic [NUM_LINKS-1:0] link_all_sent,   // link queue fully sent
   input  wire logic [NUM_LINKS-1:0] link_all_acked,  // link queue fully acked
   input  wire logic [NUM_LINKS-1:0] link_poll_out,   // poll outstanding on link
   input  wire logic                 iq_head_valid,   // transmit task pops queue head
   input  wire logic                 txdone_valid,    // link transmit work finished
   input  wire logic [LINK_W-1:0]    txdone_link,     // link of txdone_valid
   input  wire logic [2:0]           xq_done,         // global, q0, q1 queue handled
   output var  logic [2:0]           xq_sched,        // global, q0, q1 in rotation
   output var  logic                 disc_req,        // send disconnect frame pulse
   output var  logic                 unassign_req,    // set link unassigned pulse
   output var  logic [LINK_W-1:0]    req_link,        // link of disc/unassign
   output var  logic                 irq_valid,       // interrupt queue entry pulse
   output var  logic [2:0]           irq_code,        // interrupt entry kind
   output var  logic [LINK_W-1:0]    irq_link         // link of the entry
);
   import ltqc_pkg::*;

   function automatic logic [31:0] lt_addr(input logic [LINK_W-1:0] id);
      lt_addr = LT_BASE + LT_STRIDE * {{(32-LINK_W){1'b0}}, id};
   endfunction

   function automatic logic [7:0] highest_of(input logic [NUM_LINKS-1:0] act);
      logic [7:0] h;
      h = 8'h00;
      for (int i = 0; i < NUM_LINKS; i++) begin
         if (act[i]) begin
            h = 8'(i);
         end
      end
      highest_of = h;
   endfunction

   // link tables kept on chip
   logic [15:0]       txst_reg   [NUM_LINKS];
   logic [15:0]       txst_next  [NUM_LINKS];
   logic [31:0]       nptr_reg   [NUM_LINKS];
   logic [31:0]       nptr_next  [NUM_LINKS];
   logic [31:0]       aptr_reg   [NUM_LINKS];
   logic [31:0]       aptr_next  [NUM_LINKS];
   logic [LINK_W-1:0] chain_reg  [NUM_LINKS];
   logic [LINK_W-1:0] chain_next [NUM_LINKS];
   logic [31:0]       chaddr_reg [NUM_LINKS];
   logic [31:0]       chaddr_next[NUM_LINKS];
   logic [NUM_LINKS-1:0] inq_reg, inq_next, rmv_reg, rmv_next;

   ltqc_state_t       st_reg, st_next;
   logic [7:0]        cmd_reg, cmd_next, sem_reg, sem_next, high_reg, high_next;
   logic [31:0]       arg1_reg, arg1_next, arg2_reg, arg2_next;
   logic [31:0]       ghead_reg, ghead_next, q0head_reg, q0head_next;
   logic [31:0]       q1head_reg, q1head_next;
   logic [2:0]        xq_next;
   logic [LINK_W-1:0] qhead_reg, qhead_next, qtail_reg, qtail_next;
   logic              qempty_reg, qempty_next;
   logic              disc_next, unas_next, irqv_next;
   logic [LINK_W-1:0] rlink_next, irql_next;
   logic [2:0]        irqc_next;
   logic [NUM_LINKS-1:0] act_vec;

   // axi state
   logic        awh_reg, awh_next, wh_reg, wh_next, bv_reg, bv_next, rv_reg, rv_next;
   logic [7:0]  awa_reg, awa_next;
   logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
   logic [1:0]  br_reg, br_next, rr_reg, rr_next;
   logic        wr_fire, cmd_wr;

   wire logic [LINK_W-1:0] lid = arg1_reg[LINK_W-1:0];

   always_comb begin
      for (int i = 0; i < NUM_LINKS; i++) begin
         act_vec[i] = txst_reg[i][`LTQC_ACTIVE_BIT];
      end
   end

   // write path: address and data are taken in either order
   always_comb begin
      awh_next = awh_reg;
      wh_next  = wh_reg;
      awa_next = awa_reg;
      wd_next  = wd_reg;
      bv_next  = bv_reg;
      br_next  = br_reg;
      wr_fire  = 1'b0;
      if (s_axi_awvalid && !awh_reg) begin
         awh_next = 1'b1;
         awa_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wh_reg) begin
         wh_next = 1'b1;
         wd_next = s_axi_wdata;
      end
      if (awh_reg && wh_reg && !bv_reg) begin
         wr_fire  = 1'b1;
         awh_next = 1'b0;
         wh_next  = 1'b0;
         bv_next  = 1'b1;
         if (awa_reg == `LTQC_A_CMD || awa_reg == `LTQC_A_ARG1 || awa_reg == `LTQC_A_ARG2) begin
            br_next = `LTQC_RESP_OKAY;
         end else if (awa_reg <= `LTQC_A_QUEUE && awa_reg[1:0] == 2'b00) begin
            br_next = `LTQC_RESP_OKAY;
         end else begin
            br_next = `LTQC_RESP_SLVERR;
         end
      end else if (bv_reg && s_axi_bready) begin
         bv_next = 1'b0;
      end
   end

   // read path: one cycle from address to data
   always_comb begin
      rv_next = rv_reg;
      rd_next = rd_reg;
      rr_next = rr_reg;
      if (s_axi_arvalid && !rv_reg) begin
         rv_next = 1'b1;
         rr_next = `LTQC_RESP_OKAY;
         if (s_axi_araddr == `LTQC_A_CMD) begin
            rd_next = {24'h0, cmd_reg};
         end else if (s_axi_araddr == `LTQC_A_ARG1) begin
            rd_next = arg1_reg;
         end else if (s_axi_araddr == `LTQC_A_ARG2) begin
            rd_next = arg2_reg;
         end else if (s_axi_araddr == `LTQC_A_SEM) begin
            rd_next = {24'h0, sem_reg};
         end else if (s_axi_araddr == `LTQC_A_GHEAD) begin
            rd_next = ghead_reg;
         end else if (s_axi_araddr == `LTQC_A_Q0HEAD) begin
            rd_next = q0head_reg;
         end else if (s_axi_araddr == `LTQC_A_Q1HEAD) begin
            rd_next = q1head_reg;
         end else if (s_axi_araddr == `LTQC_A_HIGHEST) begin
            rd_next = {24'h0, high_reg};
         end else if (s_axi_araddr == `LTQC_A_LSTAT) begin
            rd_next = {inq_reg[lid], rmv_reg[lid], 14'h0, txst_reg[lid]};
         end else if (s_axi_araddr == `LTQC_A_QUEUE) begin
            rd_next = {15'h0, qempty_reg, 8'(qtail_reg), 8'(qhead_reg)};
         end else begin
            rd_next = 32'h0;
            rr_next = `LTQC_RESP_SLVERR;
         end
      end else if (rv_reg && s_axi_rready) begin
         rv_next = 1'b0;
      end
   end

   // a new opcode is taken only while the previous one has finished
   assign cmd_wr = wr_fire && awa_reg == `LTQC_A_CMD && st_reg == LTQC_ST_IDLE;

   always_comb begin
      st_next     = st_reg;
      cmd_next    = cmd_reg;
      sem_next    = sem_reg;
      arg1_next   = arg1_reg;
      arg2_next   = arg2_reg;
      ghead_next  = ghead_reg;
      q0head_next = q0head_reg;
      q1head_next = q1head_reg;
      xq_next     = xq_sched & ~xq_done;
      qhead_next  = qhead_reg;
      qtail_next  = qtail_reg;
      qempty_next = qempty_reg;
      inq_next    = inq_reg;
      rmv_next    = rmv_reg;
      disc_next   = 1'b0;
      unas_next   = 1'b0;
      rlink_next  = req_link;
      irqv_next   = 1'b0;
      irqc_next   = irq_code;
      irql_next   = irq_link;
      for (int i = 0; i < NUM_LINKS; i++) begin
         txst_next[i]   = txst_reg[i];
         nptr_next[i]   = nptr_reg[i];
         aptr_next[i]   = aptr_reg[i];
         chain_next[i]  = chain_reg[i];
         chaddr_next[i] = chaddr_reg[i];
      end
      if (wr_fire && awa_reg == `LTQC_A_ARG1 && st_reg == LTQC_ST_IDLE) begin
         arg1_next = wd_reg;
      end
      if (wr_fire && awa_reg == `LTQC_A_ARG2 && st_reg == LTQC_ST_IDLE) begin
         arg2_next = wd_reg;
      end
      // transmit task pops the head; a pending removal completes here
      if (iq_head_valid && !qempty_reg) begin
         inq_next[qhead_reg] = 1'b0;
         if (rmv_reg[qhead_reg]) begin
            txst_next[qhead_reg][`LTQC_ACTIVE_BIT] = 1'b0;
            rmv_next[qhead_reg] = 1'b0;
         end
         if (qhead_reg == qtail_reg) begin
            qempty_next = 1'b1;
         end else begin
            qhead_next = chain_reg[qhead_reg];
         end
      end
      // interrupt sources, lower priority than command results
      if (txdone_valid) begin
         irqv_next = 1'b1;
         irqc_next = `LTQC_IRQ_TXDONE;
         irql_next = txdone_link;
      end else if (xq_done[0] && xq_sched[0]) begin
         irqv_next = 1'b1;
         irqc_next = `LTQC_IRQ_GDONE;
      end else if (xq_done[1] && xq_sched[1]) begin
         irqv_next = 1'b1;
         irqc_next = `LTQC_IRQ_Q0DONE;
      end else if (xq_done[2] && xq_sched[2]) begin
         irqv_next = 1'b1;
         irqc_next = `LTQC_IRQ_Q1DONE;
      end
      case (st_reg)
         LTQC_ST_IDLE: begin
            if (cmd_wr) begin
               cmd_next = wd_reg[7:0];
               sem_next = `LTQC_SEM_BUSY;
               st_next  = LTQC_ST_EXEC;
            end
         end
         LTQC_ST_EXEC: begin
            st_next  = LTQC_ST_IDLE;
            sem_next = `LTQC_SEM_DONE;
            if (cmd_reg == `LTQC_OP_ENQ || cmd_reg == `LTQC_OP_RELINK) begin
               if ((cmd_reg == `LTQC_OP_ENQ && link_all_sent[lid] && link_all_acked[lid])
                   || (cmd_reg == `LTQC_OP_RELINK && link_all_sent[lid]
                   && !link_all_acked[lid] && !link_poll_out[lid] && !inq_reg[lid])) begin
                  if (!qempty_next) begin
                     chain_next[qtail_reg]  = lid;
                     chaddr_next[qtail_reg] = lt_addr(lid);
                  end else begin
                     qhead_next = lid;
                  end
                  qtail_next    = lid;
                  qempty_next   = 1'b0;
                  inq_next[lid] = 1'b1;
                  if (cmd_reg == `LTQC_OP_ENQ) begin
                     txst_next[lid] = `LTQC_TXSTATE_INIT;
                     nptr_next[lid] = arg2_reg;
                     aptr_next[lid] = arg2_reg;
                  end
               end else if (cmd_reg == `LTQC_OP_ENQ) begin
                  irqv_next = 1'b1;
                  irqc_next = `LTQC_IRQ_ERR;
                  irql_next = lid;
               end
            end else if (cmd_reg == `LTQC_OP_GLOBAL || cmd_reg == `LTQC_OP_XQ0
                         || cmd_reg == `LTQC_OP_XQ1) begin
               for (int k = 0; k < 3; k++) begin
                  if (cmd_reg == (k == 0 ? `LTQC_OP_GLOBAL : k == 1 ? `LTQC_OP_XQ0
                                  : `LTQC_OP_XQ1)) begin
                     if (xq_sched[k] && !xq_done[k]) begin
                        irqv_next = 1'b1;
                        irqc_next = `LTQC_IRQ_ERR;
                        irql_next = lid;
                     end else begin
                        xq_next[k] = 1'b1;
                        if (k == 0) begin
                           ghead_next = arg2_reg;
                        end else if (k == 1) begin
                           q0head_next = arg2_reg;
                        end else begin
                           q1head_next = arg2_reg;
                        end
                     end
                  end
               end
            end else if (cmd_reg == `LTQC_OP_ERRRSP) begin
               unas_next  = 1'b1;
               rlink_next = lid;
            end else if (cmd_reg == `LTQC_OP_RELEASE) begin
               disc_next  = 1'b1;
               rlink_next = lid;
            end else if (cmd_reg == `LTQC_OP_REMOVE) begin
               unas_next  = 1'b1;
               rlink_next = lid;
               if (inq_next[lid]) begin
                  rmv_next[lid] = 1'b1;
               end else begin
                  txst_next[lid][`LTQC_ACTIVE_BIT] = 1'b0;
               end
            end
         end
         default: begin
            st_next = LTQC_ST_IDLE;
         end
      endcase
   end

   // highest active link follows active bits one cycle later
   assign high_next = highest_of(act_vec);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= LTQC_ST_IDLE;
         cmd_reg <= 8'h00;
         sem_reg <= `LTQC_SEM_DONE;
         arg1_reg <= 32'h0;
         arg2_reg <= 32'h0;
         ghead_reg <= 32'h0;
         q0head_reg <= 32'h0;
         q1head_reg <= 32'h0;
         high_reg <= 8'h00;
         xq_sched <= 3'h0;
         qhead_reg <= '0;
         qtail_reg <= '0;
         qempty_reg <= 1'b1;
         inq_reg <= '0;
         rmv_reg <= '0;
         disc_req <= 1'b0;
         unassign_req <= 1'b0;
         req_link <= '0;
         irq_valid <= 1'b0;
         irq_code <= `LTQC_IRQ_NONE;
         irq_link <= '0;
         for (int i = 0; i < NUM_LINKS; i++) begin
            txst_reg[i] <= 16'h0;
            nptr_reg[i] <= 32'h0;
            aptr_reg[i] <= 32'h0;
            chain_reg[i] <= '0;
            chaddr_reg[i] <= 32'h0;
         end
         awh_reg <= 1'b0;
         wh_reg <= 1'b0;
         awa_reg <= 8'h00;
         wd_reg <= 32'h0;
         bv_reg <= 1'b0;
         br_reg <= 2'h0;
         rv_reg <= 1'b0;
         rd_reg <= 32'h0;
         rr_reg <= 2'h0;
      end else begin
         st_reg <= st_next;
         cmd_reg <= cmd_next;
         sem_reg <= sem_next;
         arg1_reg <= arg1_next;
         arg2_reg <= arg2_next;
         ghead_reg <= ghead_next;
         q0head_reg <= q0head_next;
         q1head_reg <= q1head_next;
         high_reg <= high_next;
         xq_sched <= xq_next;
         qhead_reg <= qhead_next;
         qtail_reg <= qtail_next;
         qempty_reg <= qempty_next;
         inq_reg <= inq_next;
         rmv_reg <= rmv_next;
         disc_req <= disc_next;
         unassign_req <= unas_next;
         req_link <= rlink_next;
         irq_valid <= irqv_next;
         irq_code <= irqc_next;
         irq_link <= irql_next;
         for (int i = 0; i < NUM_LINKS; i++) begin
            txst_reg[i] <= txst_next[i];
            nptr_reg[i] <= nptr_next[i];
            aptr_reg[i] <= aptr_next[i];
            chain_reg[i] <= chain_next[i];
            chaddr_reg[i] <= chaddr_next[i];
         end
         awh_reg <= awh_next;
         wh_reg <= wh_next;
         awa_reg <= awa_next;
         wd_reg <= wd_next;
         bv_reg <= bv_next;
         br_reg <= br_next;
         rv_reg <= rv_next;
         rd_reg <= rd_next;
         rr_reg <= rr_next;
      end
   end

   assign s_axi_awready = !awh_reg;
   assign s_axi_wready  = !wh_reg;
   assign s_axi_bvalid  = bv_reg;
   assign s_axi_bresp   = br_reg;
   assign s_axi_arready = !rv_reg;
   assign s_axi_rvalid  = rv_reg;
   assign s_axi_rdata   = rd_reg;
   assign s_axi_rresp   = rr_reg;

   a_enq_init: assert property (@(posedge clk) disable iff (!rstn)
      st_reg == LTQC_ST_EXEC && cmd_reg == `LTQC_OP_ENQ && link_all_sent[lid]
      && link_all_acked[lid] |=> txst_reg[$past(lid)] == `LTQC_TXSTATE_INIT
      && nptr_reg[$past(lid)] == $past(arg2_reg))
      else $error("enqueue did not initialise link table");
   a_enq_refuse: assert property (@(posedge clk) disable iff (!rstn)
      st_reg == LTQC_ST_EXEC && cmd_reg == `LTQC_OP_ENQ && !link_all_acked[lid]
      |=> irq_valid && irq_code == `LTQC_IRQ_ERR && !$changed(qtail_reg))
      else $error("refused enqueue gave no error entry");
   a_sem_done: assert property (@(posedge clk) disable iff (!rstn)
      cmd_wr |=> sem_reg == `LTQC_SEM_BUSY ##1 sem_reg == `LTQC_SEM_DONE)
      else $error("semaphore not busy then done");
   a_chain_tail: assert property (@(posedge clk) disable iff (!rstn)
      st_reg == LTQC_ST_EXEC && cmd_reg == `LTQC_OP_ENQ && link_all_sent[lid]
      && link_all_acked[lid] && !qempty_reg && !iq_head_valid
      |=> chaddr_reg[$past(qtail_reg)] == lt_addr($past(lid)) && qtail_reg == $past(lid))
      else $error("link not chained to tail");
   a_relink_block: assert property (@(posedge clk) disable iff (!rstn)
      st_reg == LTQC_ST_EXEC && cmd_reg == `LTQC_OP_RELINK && link_poll_out[lid]
      |=> $stable(qtail_reg) && sem_reg == `LTQC_SEM_DONE)
      else $error("blocked relink changed queue");
   a_xq_refuse: assert property (@(posedge clk) disable iff (!rstn)
      st_reg == LTQC_ST_EXEC && cmd_reg == `LTQC_OP_GLOBAL && xq_sched[0] && !xq_done[0]
      |=> irq_code == `LTQC_IRQ_ERR && $stable(ghead_reg))
      else $error("busy global request accepted");
   a_global_load: assert property (@(posedge clk) disable iff (!rstn)
      st_reg == LTQC_ST_EXEC && cmd_reg == `LTQC_OP_GLOBAL && !xq_sched[0]
      |=> ghead_reg == $past(arg2_reg) && xq_sched[0])
      else $error("global head not loaded");
   a_release_disc: assert property (@(posedge clk) disable iff (!rstn)
      st_reg == LTQC_ST_EXEC && cmd_reg == `LTQC_OP_RELEASE
      |=> disc_req && req_link == $past(lid) ##1 !disc_req)
      else $error("release gave no single disconnect pulse");
   a_remove_idle: assert property (@(posedge clk) disable iff (!rstn)
      st_reg == LTQC_ST_EXEC && cmd_reg == `LTQC_OP_REMOVE && !inq_reg[lid]
      |=> unassign_req && !txst_reg[$past(lid)][`LTQC_ACTIVE_BIT])
      else $error("remove of unqueued link left it active");
endmodule
`default_nettype wire

// ===== ltqc_defines.svh
// constants of the link transmit queue command handler
`ifndef LTQC_DEFINES_SVH
`define LTQC_DEFINES_SVH
`define LTQC_OP_ENQ      8'ha0
`define LTQC_OP_RELINK   8'h6b
`define LTQC_OP_GLOBAL   8'h22
`define LTQC_OP_XQ0      8'h26
`define LTQC_OP_XQ1      8'h27
`define LTQC_OP_ERRRSP   8'h68
`define LTQC_OP_RELEASE  8'h64
`define LTQC_OP_REMOVE   8'h6c
`define LTQC_TXSTATE_INIT 16'h000f
`define LTQC_ACTIVE_BIT  0
`define LTQC_SEM_DONE    8'hff
`define LTQC_SEM_BUSY    8'h00
`define LTQC_A_CMD       8'h00
`define LTQC_A_ARG1      8'h04
`define LTQC_A_ARG2      8'h08
`define LTQC_A_SEM       8'h0c
`define LTQC_A_GHEAD     8'h10
`define LTQC_A_Q0HEAD    8'h14
`define LTQC_A_Q1HEAD    8'h18
`define LTQC_A_HIGHEST   8'h1c
`define LTQC_A_LSTAT     8'h20
`define LTQC_A_QUEUE     8'h24
`define LTQC_IRQ_NONE    3'h0
`define LTQC_IRQ_ERR     3'h1
`define LTQC_IRQ_TXDONE  3'h2
`define LTQC_IRQ_GDONE   3'h3
`define LTQC_IRQ_Q0DONE  3'h4
`define LTQC_IRQ_Q1DONE  3'h5
`define LTQC_RESP_OKAY   2'h0
`define LTQC_RESP_SLVERR 2'h2
`endif

// ===== ltqc_pkg.sv
// types of the link transmit queue command handler
package ltqc_pkg;
   typedef enum logic [1:0] {
      LTQC_ST_IDLE = 2'b01,
      LTQC_ST_EXEC = 2'b10
   } ltqc_state_t;
   typedef logic [31:0] ltqc_word_t;
endpackage

// ===== ltqc_host.sv
// host model: axi4-lite master that issues commands through the control block
`timescale 1ns/1ps
`default_nettype none
`include "ltqc_defines.svh"
module ltqc_host (
   input wire logic clk // bus clock
);
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [1:0]  bresp, rresp, rsp;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, hung = 0;
   logic        awready, wready, bvalid, arready, rvalid;
   // one transfer at a time; each channel is released only at the edge that takes it
   task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n = 0;
      @(posedge clk);
      {awaddr, araddr, wdata} <= {a, a, wd};
      {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (arready) arvalid <= 1'b0;
         n++;
      end while ((w ? bvalid : rvalid) !== 1'b1 && n < 50);
      {bready, rready} <= 2'h0;
      hung = hung | (n == 50);
      rd = rdata;
      rsp = w ? bresp : rresp;
   endtask
   // polling the semaphore keeps a new command from landing on a busy handler
   task automatic cmd(input logic [7:0] op, input logic [31:0] a1, input logic [31:0] a2);
      logic [31:0] s;
      bus(1, `LTQC_A_ARG1, a1, s);
      bus(1, `LTQC_A_ARG2, a2, s);
      bus(1, `LTQC_A_CMD, {24'h0, op}, s);
      s = 0;
      for (int n = 0; n < 20 && s !== 32'hff; n++)
         bus(0, `LTQC_A_SEM, 0, s);
      hung = hung | (s !== 32'hff);
   endtask
endmodule
`default_nettype wire

// ===== link_tx_queue_command_handler_test.sv
// self-checking bench of the link transmit queue command handler
`timescale 1ns/1ps
`default_nettype none
`include "ltqc_defines.svh"
module link_tx_queue_command_handler_test;
   logic [7:0]  sent = 0, acked = 0, poll = 0, ops[3];
   logic        clk = 0, rstn = 0, pop = 0, txd = 0, disc, unas, irqv;
   logic [2:0]  done = 0, tl = 0, sched, code, rl, il;
   logic [31:0] v, hd;
   int          failures = 0, n_checks = 0, iq[$], ev[$], q[$], lq[$];
   ltqc_host h (.clk(clk));
   ltqc_top u_dut (.clk(clk), .rstn(rstn), .s_axi_awaddr(h.awaddr), .s_axi_awvalid(h.awvalid),
      .s_axi_awready(h.awready), .s_axi_wdata(h.wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(h.wvalid), .s_axi_wready(h.wready), .s_axi_bresp(h.bresp),
      .s_axi_bvalid(h.bvalid), .s_axi_bready(h.bready), .s_axi_araddr(h.araddr),
      .s_axi_arvalid(h.arvalid), .s_axi_arready(h.arready), .s_axi_rdata(h.rdata),
      .s_axi_rresp(h.rresp), .s_axi_rvalid(h.rvalid), .s_axi_rready(h.rready),
      .link_all_sent(sent), .link_all_acked(acked), .link_poll_out(poll), .iq_head_valid(pop),
      .txdone_valid(txd), .txdone_link(tl), .xq_done(done), .xq_sched(sched), .disc_req(disc),
      .unassign_req(unas), .req_link(rl), .irq_valid(irqv), .irq_code(code), .irq_link(il));
   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      if (irqv === 1'b1) iq.push_back(code);
      if (irqv === 1'b1) lq.push_back(il);
      if ((disc | unas) === 1'b1) ev.push_back({disc, unas, rl});
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge h.hung) begin
      failures++;
      tally_and_finish();
   end
   task automatic qchk; // queue register against the model's head and tail
      h.bus(0, `LTQC_A_QUEUE, 0, v);
      chk(v[16:0], {1'b0, 8'(q[$]), 8'(q[0])});
   endtask
   initial begin
      void'($urandom(21192));
      ops = '{`LTQC_OP_GLOBAL, `LTQC_OP_XQ0, `LTQC_OP_XQ1};
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      h.bus(0, `LTQC_A_SEM, 0, v);
      chk(v, 32'hff);
      h.bus(0, 8'h30, 0, v);
      chk(h.rsp, `LTQC_RESP_SLVERR);
      h.bus(1, 8'h30, 0, v);
      chk(h.rsp, `LTQC_RESP_SLVERR);
      {sent, acked} <= 16'hff08;
      h.cmd(`LTQC_OP_ENQ, 3, $urandom);
      q.push_back(3);
      h.bus(0, `LTQC_A_LSTAT, 0, v);
      chk(v[15:0], `LTQC_TXSTATE_INIT);
      qchk();
      h.bus(0, `LTQC_A_HIGHEST, 0, v);
      chk(v, 3);
      h.cmd(`LTQC_OP_ENQ, 4, 0);
      chk(iq.pop_front(), `LTQC_IRQ_ERR);
      chk(lq[$], 4);
      {acked, poll} <= 16'h0040;
      h.cmd(`LTQC_OP_RELINK, 5, 0);
      q.push_back(5);
      h.cmd(`LTQC_OP_RELINK, 6, 0);
      qchk();
      $display("link queue test done");
      for (int k = 0; k < 3; k++) begin
         hd = $urandom;
         h.cmd(ops[k], 0, hd);
         h.cmd(ops[k], 0, ~hd);
         h.bus(0, `LTQC_A_GHEAD + 8'(4 * k), 0, v);
         chk(v, hd);
         chk(sched, 3'h1 << k);
         done <= 3'h1 << k;
         @(posedge clk);
         done <= 3'h0;
         repeat (3) @(posedge clk);
         chk(sched, 3'h0);
         chk(iq.pop_front(), `LTQC_IRQ_ERR);
         chk(iq.pop_front(), `LTQC_IRQ_GDONE + 3'(k));
      end
      $display("exchange queue test done");
      h.cmd(`LTQC_OP_RELEASE, 2, 0);
      h.cmd(`LTQC_OP_ERRRSP, 1, 0);
      h.cmd(`LTQC_OP_REMOVE, 3, 0);
      chk(ev.pop_front(), 5'h12);
      chk(ev.pop_front(), 5'h09);
      chk(ev.pop_front(), 5'h0b);
      h.bus(0, `LTQC_A_LSTAT, 0, v);
      chk(v[0], 1'b1);
      chk(v[31:30], 2'b11);
      pop <= 1'b1;
      @(posedge clk);
      pop <= 1'b0;
      void'(q.pop_front());
      h.bus(0, `LTQC_A_LSTAT, 0, v);
      chk(v[0], 1'b0);
      qchk();
      {acked, poll} <= 16'h0400;
      h.cmd(`LTQC_OP_ENQ, 2, hd);
      q.push_back(2);
      qchk();
      h.bus(0, `LTQC_A_HIGHEST, 0, v);
      chk(v, 2);
      h.cmd(`LTQC_OP_REMOVE, 6, 0);
      chk(ev.pop_front(), 5'h0e);
      {tl, txd} <= 4'hb;
      @(posedge clk);
      txd <= 1'b0;
      repeat (3) @(posedge clk);
      chk(iq.pop_front(), `LTQC_IRQ_TXDONE);
      chk(lq[$], 5);
      chk(iq.size() + ev.size(), 0);
      $display("link state test done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
